// ### rtcc_regs.vh
// register offsets, field positions, reset values and timing counts
// of the time/calendar/alarm core; included by the core module only
`ifndef RTCC_REGS_VH
`define RTCC_REGS_VH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define RTCC_ADDR_CTRL    4'h0
`define RTCC_ADDR_FLAGS   4'h1
`define RTCC_ADDR_SEC     4'h2
`define RTCC_ADDR_MIN     4'h3
`define RTCC_ADDR_HOUR    4'h4
`define RTCC_ADDR_DATE    4'h5
`define RTCC_ADDR_WDAY    4'h6
`define RTCC_ADDR_MONTH   4'h7
`define RTCC_ADDR_YEAR    4'h8
`define RTCC_ADDR_ALMIN   4'h9
`define RTCC_ADDR_ALHOUR  4'ha
`define RTCC_ADDR_ALDATE  4'hb
`define RTCC_ADDR_ALWDAY  4'hc

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define RTCC_CTRL_TEST_BIT    7
`define RTCC_CTRL_STOP_BIT    5
`define RTCC_CTRL_PERMIT_BIT  3
`define RTCC_FLG_LVLPLS_BIT   4
`define RTCC_FLG_ALARM_BIT    3
`define RTCC_FLG_CDOWN_BIT    2
`define RTCC_FLG_AIE_BIT      1
`define RTCC_FLG_CIE_BIT      0
`define RTCC_SEC_OSC_BIT      7
`define RTCC_MON_CENT_BIT     7
`define RTCC_AL_DIS_BIT       7

// ----------------------------------------------------------------------
// field masks and counter limits (bcd)
// ----------------------------------------------------------------------
`define RTCC_MASK_SEC     8'h7f
`define RTCC_MASK_HOUR    8'h3f
`define RTCC_MASK_DATE    8'h3f
`define RTCC_MASK_WDAY    8'h07
`define RTCC_MASK_MONTH   8'h1f
`define RTCC_MAX_SEC      7'h59
`define RTCC_MAX_HOUR     6'h23
`define RTCC_MAX_WDAY     3'h6
`define RTCC_MAX_MONTH    5'h12
`define RTCC_MAX_YEAR     8'h99
`define RTCC_DAYS_LONG    8'h31
`define RTCC_DAYS_SHORT   8'h30
`define RTCC_DAYS_FEBLEAP 8'h29
`define RTCC_DAYS_FEB     8'h28

// ----------------------------------------------------------------------
// reset values and timing
// ----------------------------------------------------------------------
`define RTCC_RST_CTRL     8'h08
`define RTCC_PRESC_HALF   6'h1f
`define RTCC_POR_CYCLES   16'h0400

`endif

// ### rtcc_bcd_counter.v
// one bcd counter with load, increment and a variable upper limit
// assumes load and increment come from logic on sys_clk
`timescale 1ns/1ps

module rtcc_bcd_counter #(
    parameter       W         = 8,
    parameter [7:0] RESET_VAL = 8'h00
) (
    input  wire         sys_clk,
    input  wire         rst,
    input  wire         loadEn,
    input  wire [W-1:0] loadVal,
    input  wire         incEn,
    input  wire [W-1:0] minVal,
    input  wire [W-1:0] maxVal,
    output reg  [W-1:0] value_r,
    output wire         wrapHit
);

    reg [W-1:0] value_nxt;
    reg [7:0]   wideVal;
    reg [7:0]   wideNxt;

    // ------------------------------------------------------------------
    // wrap detect: increment at the upper limit
    // ------------------------------------------------------------------
    assign wrapHit = incEn & (value_r == maxVal);

    // next value: load first, then wrap to the low limit, else bcd +1
    always @* begin
        wideVal = 8'h00;
        wideVal[W-1:0] = value_r; // widened for narrow counters
        wideNxt = (wideVal[3:0] == 4'h9) ? wideVal + 8'h07 : wideVal + 8'h01;
        value_nxt = value_r;
        if (loadEn) begin
            value_nxt = loadVal;
        end else if (wrapHit) begin
            value_nxt = minVal;
        end else if (incEn) begin
            value_nxt = wideNxt[W-1:0]; // 9 -> next ten
        end
    end

    // counter register
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            value_r <= RESET_VAL[W-1:0];
        end else begin
            value_r <= value_nxt;
        end
    end

endmodule

// ### rtcc_core.v
// time, calendar and alarm core with external-tick test mode and
// power-on-reset override; registers on a simple word port
// assumes tick64 is a one-cycle pulse on sys_clk, pins are asynchronous
`timescale 1ns/1ps
`include "rtcc_regs.vh"

module rtcc_core #(
    parameter [15:0] POR_CYCLES = `RTCC_POR_CYCLES
) (
    input  wire       sys_clk,
    input  wire       rst,
    input  wire       tick64,
    input  wire [3:0] regAddr,
    input  wire [7:0] regWrData,
    input  wire       regWrEn,
    output reg  [7:0] regRdData_r,
    input  wire       sqwSrc,
    input  wire       sqwIn,
    output reg        sqwOut_r,
    output reg        sqwOe_r,
    input  wire       sclIn,
    input  wire       sdaIn,
    output reg        porActive_r,
    output reg        overrideMode_r,
    output reg        alarmFlag_r,
    output reg        secondPulse_r
);

    // ------------------------------------------------------------------
    // override sequence states
    // ------------------------------------------------------------------
    localparam [2:0] OV_IDLE = 3'd0;
    localparam [2:0] OV_SDLO = 3'd1;
    localparam [2:0] OV_SCLO = 3'd2;
    localparam [2:0] OV_SDHI = 3'd3;
    localparam [2:0] OV_DONE = 3'd4;

    reg        testMode_r;
    reg        stop_r;
    reg        permit_r;
    reg        lvlPulse_r;
    reg        cdownFlag_r;
    reg        alarmIe_r;
    reg        cdownIe_r;
    reg        oscFlag_r;
    reg        century_r;
    reg [7:0]  alMin_r;
    reg [7:0]  alHour_r;
    reg [7:0]  alDate_r;
    reg [7:0]  alWday_r;
    reg [5:0]  presc_r;
    reg [5:0]  presc_nxt;
    reg [15:0] porCnt_r;
    reg        matchPrev_r;
    reg [2:0]  ovState_r;
    reg [2:0]  ovState_nxt;
    reg [1:0]  sqwSync_r;
    reg        sqwPrev_r;
    reg [1:0]  sclSync_r;
    reg [1:0]  sdaSync_r;
    reg [7:0]  rdMux;
    reg [7:0]  lastDay;

    wire [6:0] secVal;
    wire [6:0] minVal;
    wire [5:0] hourVal;
    wire [5:0] dateVal;
    wire [2:0] wdayVal;
    wire [4:0] monVal;
    wire [7:0] yearVal;
    wire       secWrap;
    wire       minWrap;
    wire       hourWrap;
    wire       dateWrap;
    wire       wdayWrap;
    wire       monWrap;
    wire       yearWrap;

    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    // two flip-flops per asynchronous pin, edge detect on the second for the square-wave pin only
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            sqwSync_r <= 2'b00;
            sqwPrev_r <= 1'b0;
            sclSync_r <= 2'b11;
            sdaSync_r <= 2'b11;
        end else begin
            sqwSync_r <= {sqwSync_r[0], sqwIn};
            sqwPrev_r <= sqwSync_r[1];
            sclSync_r <= {sclSync_r[0], sclIn};
            sdaSync_r <= {sdaSync_r[0], sdaIn};
        end
    end

    wire sqwRise = sqwSync_r[1] & ~sqwPrev_r;
    wire sclNow  = sclSync_r[1];
    wire sdaNow  = sdaSync_r[1];

    // ------------------------------------------------------------------
    // tick source and pre-scaler
    // ------------------------------------------------------------------
    // rising pin edges stand in for the internal tick in test mode
    wire tickSel = testMode_r ? sqwRise : tick64;
    wire runTime = ~porActive_r;
    wire secInc  = runTime & ~stop_r & tickSel &
                   (presc_r == `RTCC_PRESC_HALF);

    // six-bit divider, held at zero while stopped
    always @* begin
        presc_nxt = presc_r;
        if (stop_r) begin
            presc_nxt = 6'h00;
        end else if (runTime & tickSel) begin
            presc_nxt = presc_r + 6'h01;
        end
    end

    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            presc_r       <= 6'h00;
            secondPulse_r <= 1'b0;
        end else begin
            presc_r       <= presc_nxt;
            secondPulse_r <= secInc;
        end
    end

    // ------------------------------------------------------------------
    // register write strobes
    // ------------------------------------------------------------------
    wire wrOk   = regWrEn & ~porActive_r;
    wire wrSec  = wrOk & (regAddr == `RTCC_ADDR_SEC);
    wire wrMin  = wrOk & (regAddr == `RTCC_ADDR_MIN);
    wire wrHour = wrOk & (regAddr == `RTCC_ADDR_HOUR);
    wire wrDate = wrOk & (regAddr == `RTCC_ADDR_DATE);
    wire wrWday = wrOk & (regAddr == `RTCC_ADDR_WDAY);
    wire wrMon  = wrOk & (regAddr == `RTCC_ADDR_MONTH);
    wire wrYear = wrOk & (regAddr == `RTCC_ADDR_YEAR);

    // ------------------------------------------------------------------
    // month length
    // ------------------------------------------------------------------
    // multiples of four in bcd: even tens with 0/4/8, odd tens with 2/6
    wire leapYear = yearVal[4] ?
        ((yearVal[3:0] == 4'h2) | (yearVal[3:0] == 4'h6)) :
        ((yearVal[3:0] == 4'h0) | (yearVal[3:0] == 4'h4) |
         (yearVal[3:0] == 4'h8));

    // last day of the current month
    always @* begin
        case (monVal)
            5'h02:   lastDay = leapYear ? `RTCC_DAYS_FEBLEAP : `RTCC_DAYS_FEB;
            5'h04,
            5'h06,
            5'h09,
            5'h11:   lastDay = `RTCC_DAYS_SHORT;
            default: lastDay = `RTCC_DAYS_LONG;
        endcase
    end

    // ------------------------------------------------------------------
    // time and calendar counters
    // ------------------------------------------------------------------
    // seconds 00..59
    rtcc_bcd_counter #(.W(7), .RESET_VAL(8'h00)) u_sec (
        .sys_clk (sys_clk),
        .rst     (rst),
        .loadEn  (wrSec),
        .loadVal (regWrData[6:0]),
        .incEn   (secInc & ~wrSec),
        .minVal  (7'h00),
        .maxVal  (`RTCC_MAX_SEC),
        .value_r (secVal),
        .wrapHit (secWrap)
    );

    // minutes 00..59, fed by the seconds carry
    rtcc_bcd_counter #(.W(7), .RESET_VAL(8'h00)) u_min (
        .sys_clk (sys_clk),
        .rst     (rst),
        .loadEn  (wrMin),
        .loadVal (regWrData[6:0]),
        .incEn   (secWrap & ~wrMin),
        .minVal  (7'h00),
        .maxVal  (`RTCC_MAX_SEC),
        .value_r (minVal),
        .wrapHit (minWrap)
    );

    // hours 00..23
    rtcc_bcd_counter #(.W(6), .RESET_VAL(8'h00)) u_hour (
        .sys_clk (sys_clk),
        .rst     (rst),
        .loadEn  (wrHour),
        .loadVal (regWrData[5:0]),
        .incEn   (minWrap & ~wrHour),
        .minVal  (6'h00),
        .maxVal  (`RTCC_MAX_HOUR),
        .value_r (hourVal),
        .wrapHit (hourWrap)
    );

    // weekday 0..6, advanced by the hours wrap
    rtcc_bcd_counter #(.W(3), .RESET_VAL(8'h00)) u_wday (
        .sys_clk (sys_clk),
        .rst     (rst),
        .loadEn  (wrWday),
        .loadVal (regWrData[2:0]),
        .incEn   (hourWrap & ~wrWday),
        .minVal  (3'h0),
        .maxVal  (`RTCC_MAX_WDAY),
        .value_r (wdayVal),
        .wrapHit (wdayWrap)
    );

    // date 1..last day of month
    rtcc_bcd_counter #(.W(6), .RESET_VAL(8'h01)) u_date (
        .sys_clk (sys_clk),
        .rst     (rst),
        .loadEn  (wrDate),
        .loadVal (regWrData[5:0]),
        .incEn   (hourWrap & ~wrDate),
        .minVal  (6'h01),
        .maxVal  (lastDay[5:0]),
        .value_r (dateVal),
        .wrapHit (dateWrap)
    );

    // month 1..12, fed by the date carry
    rtcc_bcd_counter #(.W(5), .RESET_VAL(8'h01)) u_mon (
        .sys_clk (sys_clk),
        .rst     (rst),
        .loadEn  (wrMon),
        .loadVal (regWrData[4:0]),
        .incEn   (dateWrap & ~wrMon),
        .minVal  (5'h01),
        .maxVal  (`RTCC_MAX_MONTH),
        .value_r (monVal),
        .wrapHit (monWrap)
    );

    // year 00..99, fed by the month carry
    rtcc_bcd_counter #(.W(8), .RESET_VAL(8'h00)) u_year (
        .sys_clk (sys_clk),
        .rst     (rst),
        .loadEn  (wrYear),
        .loadVal (regWrData),
        .incEn   (monWrap & ~wrYear),
        .minVal  (8'h00),
        .maxVal  (`RTCC_MAX_YEAR),
        .value_r (yearVal),
        .wrapHit (yearWrap)
    );

    // ------------------------------------------------------------------
    // alarm comparator
    // ------------------------------------------------------------------
    // a field with its disable bit set passes
    wire alMinOk  = alMin_r[`RTCC_AL_DIS_BIT]  | (alMin_r[6:0]  == minVal);
    wire alHourOk = alHour_r[`RTCC_AL_DIS_BIT] | (alHour_r[5:0] == hourVal);
    wire alDateOk = alDate_r[`RTCC_AL_DIS_BIT] | (alDate_r[5:0] == dateVal);
    wire alWdayOk = alWday_r[`RTCC_AL_DIS_BIT] | (alWday_r[2:0] == wdayVal);
    wire anyAlEn  = ~(alMin_r[7] & alHour_r[7] & alDate_r[7] & alWday_r[7]);
    wire alMatch  = anyAlEn & alMinOk & alHourOk & alDateOk & alWdayOk;
    wire alRise   = alMatch & ~matchPrev_r;

    // ------------------------------------------------------------------
    // power-on-reset override detector
    // ------------------------------------------------------------------
    // data falls with clock high, clock falls, data rises, clock rises
    always @* begin
        ovState_nxt = ovState_r;
        case (ovState_r)
            OV_IDLE: if (sclNow & ~sdaNow) ovState_nxt = OV_SDLO;
            OV_SDLO: if (~sclNow & ~sdaNow) ovState_nxt = OV_SCLO;
            OV_SCLO: if (~sclNow & sdaNow) ovState_nxt = OV_SDHI;
            OV_SDHI: if (sclNow & sdaNow) ovState_nxt = OV_DONE;
            OV_DONE: ovState_nxt = OV_IDLE;
            default: ovState_nxt = OV_IDLE;
        endcase
        if (~permit_r | overrideMode_r) begin
            ovState_nxt = OV_IDLE;
        end
    end

    wire ovEnter = (ovState_r == OV_DONE);

    // ------------------------------------------------------------------
    // control, flags and reset state
    // ------------------------------------------------------------------
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            testMode_r     <= 1'b0;
            stop_r         <= 1'b0;
            permit_r       <= 1'b1;
            lvlPulse_r     <= 1'b0;
            cdownFlag_r    <= 1'b0;
            alarmIe_r      <= 1'b0;
            cdownIe_r      <= 1'b0;
            alarmFlag_r    <= 1'b0;
            oscFlag_r      <= 1'b1;
            century_r      <= 1'b0;
            alMin_r        <= 8'h80;
            alHour_r       <= 8'h80;
            alDate_r       <= 8'h80;
            alWday_r       <= 8'h80;
            matchPrev_r    <= 1'b0;
            porCnt_r       <= 16'h0000;
            porActive_r    <= 1'b1;
            overrideMode_r <= 1'b0;
            ovState_r      <= OV_IDLE;
            sqwOut_r       <= 1'b0;
            sqwOe_r        <= 1'b0;
        end else begin
            ovState_r   <= ovState_nxt;
            matchPrev_r <= alMatch;
            // power-on hold, cut short by the override
            if (ovEnter) begin
                porActive_r    <= 1'b0;
                overrideMode_r <= 1'b1;
            end else if (porActive_r) begin
                if (porCnt_r == POR_CYCLES - 16'h0001) begin
                    porActive_r <= 1'b0;
                end
                porCnt_r <= porCnt_r + 16'h0001;
            end
            // square-wave pin: driven normally, input in test mode
            sqwOut_r <= sqwSrc;
            sqwOe_r  <= ~testMode_r;
            if (wrOk & (regAddr == `RTCC_ADDR_CTRL)) begin
                testMode_r <= regWrData[`RTCC_CTRL_TEST_BIT];
                stop_r     <= regWrData[`RTCC_CTRL_STOP_BIT];
                permit_r   <= regWrData[`RTCC_CTRL_PERMIT_BIT];
                if (~regWrData[`RTCC_CTRL_PERMIT_BIT] & ~ovEnter) begin
                    overrideMode_r <= 1'b0;
                end
            end
            if (wrOk & (regAddr == `RTCC_ADDR_FLAGS)) begin
                lvlPulse_r <= regWrData[`RTCC_FLG_LVLPLS_BIT];
                alarmIe_r  <= regWrData[`RTCC_FLG_AIE_BIT];
                cdownIe_r  <= regWrData[`RTCC_FLG_CIE_BIT];
                if (~regWrData[`RTCC_FLG_CDOWN_BIT]) begin
                    cdownFlag_r <= 1'b0;
                end
            end
            // sticky alarm flag: 0 clears, 1 keeps, a new match wins
            if (alRise) begin
                alarmFlag_r <= 1'b1;
            end else if (wrOk & (regAddr == `RTCC_ADDR_FLAGS) &
                         ~regWrData[`RTCC_FLG_ALARM_BIT]) begin
                alarmFlag_r <= 1'b0;
            end
            if (wrSec) begin
                oscFlag_r <= regWrData[`RTCC_SEC_OSC_BIT];
            end
            // century flips on the year wrap unless written
            if (wrMon) begin
                century_r <= regWrData[`RTCC_MON_CENT_BIT];
            end else if (yearWrap) begin
                century_r <= ~century_r;
            end
            if (wrOk & (regAddr == `RTCC_ADDR_ALMIN)) begin
                alMin_r <= regWrData;
            end
            if (wrOk & (regAddr == `RTCC_ADDR_ALHOUR)) begin
                alHour_r <= regWrData & 8'hbf;
            end
            if (wrOk & (regAddr == `RTCC_ADDR_ALDATE)) begin
                alDate_r <= regWrData & 8'hbf;
            end
            if (wrOk & (regAddr == `RTCC_ADDR_ALWDAY)) begin
                alWday_r <= regWrData & 8'h87;
            end
        end
    end

    // ------------------------------------------------------------------
    // read path
    // ------------------------------------------------------------------
    // register select; unused offsets read zero
    always @* begin
        case (regAddr)
            `RTCC_ADDR_CTRL:   rdMux = {testMode_r, 1'b0, stop_r, 1'b0,
                                        permit_r, 3'b000};
            `RTCC_ADDR_FLAGS:  rdMux = {3'b000, lvlPulse_r, alarmFlag_r,
                                        cdownFlag_r, alarmIe_r, cdownIe_r};
            `RTCC_ADDR_SEC:    rdMux = {oscFlag_r, secVal};
            `RTCC_ADDR_MIN:    rdMux = {1'b0, minVal};
            `RTCC_ADDR_HOUR:   rdMux = {2'b00, hourVal};
            `RTCC_ADDR_DATE:   rdMux = {2'b00, dateVal};
            `RTCC_ADDR_WDAY:   rdMux = {5'b00000, wdayVal};
            `RTCC_ADDR_MONTH:  rdMux = {century_r, 2'b00, monVal};
            `RTCC_ADDR_YEAR:   rdMux = yearVal;
            `RTCC_ADDR_ALMIN:  rdMux = alMin_r;
            `RTCC_ADDR_ALHOUR: rdMux = alHour_r;
            `RTCC_ADDR_ALDATE: rdMux = alDate_r;
            `RTCC_ADDR_ALWDAY: rdMux = alWday_r;
            default:           rdMux = 8'h00;
        endcase
    end

    // registered read data, one cycle behind the address
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            regRdData_r <= 8'h00;
        end else begin
            regRdData_r <= rdMux;
        end
    end

endmodule

// ### rtcc_core_sva.sv
// concurrent checks on the ports of the time/calendar/alarm core
// assumes one sys_clk domain and an active-high asynchronous rst
`timescale 1ns/1ps
module rtcc_core_sva #(
    parameter [15:0] POR_CYCLES = 16'h0400
) (
    input wire       sys_clk,
    input wire       rst,
    input wire       tick64,
    input wire [3:0] regAddr,
    input wire [7:0] regWrData,
    input wire       regWrEn,
    input wire [7:0] regRdData_r,
    input wire       sqwOe_r,
    input wire       porActive_r,
    input wire       overrideMode_r,
    input wire       alarmFlag_r,
    input wire       secondPulse_r
);
    reg [15:0] relCnt_r;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    // edges since the last reset release, saturating
    always @(posedge sys_clk or posedge rst) begin
        if (rst) relCnt_r <= 16'h0000;
        else if (relCnt_r != 16'hffff) relCnt_r <= relCnt_r + 16'h0001;
    end
    a_alarm_sticky: assert property (
        alarmFlag_r && !(regWrEn && regAddr == 4'h1 && !regWrData[3])
        |=> alarmFlag_r) else $error("alarm flag dropped");
    a_pulse_gap: assert property (
        secondPulse_r |=> !secondPulse_r [*8])
        else $error("seconds too close");
    a_pulse_cause: assert property (
        secondPulse_r && sqwOe_r |-> $past(tick64) || $past(tick64, 2))
        else $error("second without tick");
    a_por_fall: assert property (
        $fell(porActive_r) |-> overrideMode_r || (relCnt_r >= POR_CYCLES
        && relCnt_r <= POR_CYCLES + 16'h0001)) else $error("hold end");
    a_test_pin_in: assert property (
        regWrEn && regAddr == 4'h0 && regWrData[7] && !porActive_r
        |-> ##[1:2] !sqwOe_r) else $error("pin still driven");
    a_ovr_cancel: assert property (
        overrideMode_r && regWrEn && regAddr == 4'h0 && !regWrData[3]
        |-> ##[1:2] !overrideMode_r) else $error("override kept");
    a_stop_hold: assert property (
        regWrEn && regAddr == 4'h0 && regWrData[5] && !porActive_r
        |-> ##3 !secondPulse_r [*8]) else $error("counted in stop");
    a_unmapped_zero: assert property (
        regAddr >= 4'hd |=> regRdData_r == 8'h00)
        else $error("unmapped read");
    c_alarm: cover property ($rose(alarmFlag_r));
    c_second: cover property (secondPulse_r);
    c_override: cover property ($rose(overrideMode_r));
endmodule
bind rtcc_core rtcc_core_sva #(.POR_CYCLES(POR_CYCLES)) chk (
    .sys_clk(sys_clk), .rst(rst), .tick64(tick64), .regAddr(regAddr),
    .regWrData(regWrData), .regWrEn(regWrEn), .regRdData_r(regRdData_r),
    .sqwOe_r(sqwOe_r), .porActive_r(porActive_r),
    .overrideMode_r(overrideMode_r), .alarmFlag_r(alarmFlag_r),
    .secondPulse_r(secondPulse_r));

// ### rtcc_host_model.sv
// host side: register writes, pin sequences, external ticks
// assumes the core samples every input on rising sys_clk
`timescale 1ns/1ps
module rtcc_host_model (
    input  wire       sys_clk,
    output reg  [3:0] regAddr,
    output reg  [7:0] regWrData,
    output reg        regWrEn,
    output reg        sclIn,
    output reg        sdaIn,
    output reg        extClk
);
    localparam [7:0] OVR_SEQ = 8'b10000111;
    // pulled-up pins idle high
    initial {regAddr, regWrData, regWrEn, sclIn, sdaIn, extClk} = 16'h0006;
    // one write of a legal value, strobe over one edge
    task wr(input [3:0] a, input [7:0] d);
        begin
            @(negedge sys_clk) {regAddr, regWrData, regWrEn} = {a, d, 1'b1};
            @(negedge sys_clk) regWrEn = 1'b0;
        end
    endtask
    // select a register; its value is registered after one edge
    task sel(input [3:0] a);
        begin
            @(negedge sys_clk) regAddr = a;
            @(negedge sys_clk);
        end
    endtask
    // override entry order, each level held seven cycles
    task ovr;
        integer i;
        for (i = 0; i < 4; i = i + 1) begin
            @(negedge sys_clk) {sclIn, sdaIn} = OVR_SEQ[7 - 2 * i -: 2];
            repeat (6) @(negedge sys_clk);
        end
    endtask
    // external ticks, four cycles high and four low
    task ext(input integer n);
        repeat (n) begin
            @(negedge sys_clk) extClk = 1'b1;
            repeat (4) @(negedge sys_clk);
            extClk = 1'b0;
            repeat (3) @(negedge sys_clk);
        end
    endtask
endmodule

// ### tb_top.sv
// self-checking bench of the time/calendar/alarm core
// assumes the host model drives the register port and serial pins
`timescale 1ns/1ps
module tb_top;
    reg        sys_clk, rst, tick64, sqwSrc;
    wire [3:0] regAddr;
    wire [7:0] regWrData, regRdData_r;
    wire       regWrEn, sclIn, sdaIn, extClk, sqwOut_r, sqwOe_r;
    wire       porActive_r, overrideMode_r, alarmFlag_r, secondPulse_r;
    wire       sqwPin = sqwOe_r ? sqwOut_r : extClk;
    integer    miscompares, tests_run, cyc;
    rtcc_host_model host (.sys_clk(sys_clk), .regAddr(regAddr),
        .regWrData(regWrData), .regWrEn(regWrEn), .sclIn(sclIn),
        .sdaIn(sdaIn), .extClk(extClk));
    rtcc_core #(.POR_CYCLES(16'h0040)) dut (.sys_clk(sys_clk), .rst(rst),
        .tick64(tick64), .regAddr(regAddr), .regWrData(regWrData),
        .regWrEn(regWrEn), .regRdData_r(regRdData_r), .sqwSrc(sqwSrc),
        .sqwIn(sqwPin), .sqwOut_r(sqwOut_r), .sqwOe_r(sqwOe_r),
        .sclIn(sclIn), .sdaIn(sdaIn), .porActive_r(porActive_r),
        .overrideMode_r(overrideMode_r), .alarmFlag_r(alarmFlag_r),
        .secondPulse_r(secondPulse_r));
    // clock and a toggling square-wave source
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    always @(negedge sys_clk) sqwSrc <= ~sqwSrc;
    // hang guard
    always @(posedge sys_clk) begin
        cyc = cyc + 1;
        if (cyc == 40000) begin
            miscompares = miscompares + 1;
            report_and_stop;
        end
    end
    task chk(input [7:0] got, input [7:0] exp);
        begin
            tests_run = tests_run + 1;
            if (got !== exp) begin
                miscompares = miscompares + 1;
                $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    task rc(input [3:0] a, input [7:0] e);
        begin
            host.sel(a);
            chk(regRdData_r, e);
        end
    endtask
    task tk(input integer n);
        repeat (n) begin
            @(negedge sys_clk) tick64 = 1'b1;
            @(negedge sys_clk) tick64 = 1'b0;
        end
    endtask
    // stop, load seconds through years, restart with control c
    task load(input [7:0] c, input [55:0] v);
        integer k;
        begin
            host.wr(4'h0, c | 8'h20);
            chk({7'h0, sqwOut_r}, {7'h0, sqwSrc});
            for (k = 0; k < 7; k = k + 1) host.wr(4'(k + 2), v[55-8*k -: 8]);
            host.wr(4'h0, c);
        end
    endtask
    task t_rst;
        integer i;
        begin
            host.wr(4'h2, 8'h12);
            rc(4'h2, 8'h80);
            rc(4'h0, 8'h08);
            rc(4'hd, 8'h00);
            for (i = 0; i < 99 && porActive_r !== 1'b0; i = i + 1) tk(1);
        end
    endtask
    task t_cal;
        reg [0:3][55:0] st, ex;
        integer i, k;
        begin
            st = {56'h59592328060200, 56'h59592328030201,
                  56'h59592330010405, 56'h59592331021299};
            ex = {56'h00000029000200, 56'h00000001040301,
                  56'h00000001020505, 56'h00000001038100};
            for (i = 0; i < 4; i = i + 1) begin
                load(8'h08, st[i]);
                tk(31);
                rc(4'h2, 8'h59);
                tk(1);
                for (k = 0; k < 7; k = k + 1)
                    rc(4'(k + 2), ex[i][55-8*k -: 8]);
            end
        end
    endtask
    task t_alarm;
        begin
            host.wr(4'h9, 8'h05);
            host.wr(4'ha, 8'h91);
            host.wr(4'hb, 8'h80);
            host.wr(4'hc, 8'h80);
            load(8'h08, 56'h59041015030406);
            tk(32);
            rc(4'h1, 8'h08);
            host.wr(4'h1, 8'h08);
            rc(4'h1, 8'h08);
            host.wr(4'h1, 8'h00);
            rc(4'h1, 8'h00);
            load(8'h08, 56'h59041015030406);
            tk(32);
            rc(4'h1, 8'h08);
        end
    endtask
    task t_ext;
        begin
            host.wr(4'h0, 8'h88);
            rc(4'h3, 8'h05);
            chk({7'h0, sqwOe_r}, 8'h00);
            load(8'h88, 56'h10201301020305);
            host.ext(32);
            rc(4'h2, 8'h11);
            host.ext(63);
            rc(4'h2, 8'h11);
            host.ext(1);
            rc(4'h2, 8'h12);
            host.wr(4'h0, 8'h08);
        end
    endtask
    task t_ovr;
        begin
            @(negedge sys_clk) rst = 1'b1;
            @(negedge sys_clk) rst = 1'b0;
            host.ovr;
            chk({6'h0, porActive_r, overrideMode_r}, 8'h01);
            host.wr(4'h0, 8'h00);
            rc(4'h0, 8'h00);
            chk({7'h0, overrideMode_r}, 8'h00);
            host.ovr;
            chk({7'h0, overrideMode_r}, 8'h00);
            host.wr(4'h0, 8'h08);
            host.ovr;
            chk({7'h0, overrideMode_r}, 8'h01);
        end
    endtask
    task report_and_stop;
        begin
            $display("checks %0d mismatches %0d", tests_run, miscompares);
            if (miscompares == 0 && tests_run > 0)
                $display("RESULT: PASS");
            else
                $display("RESULT: FAIL");
            $finish;
        end
    endtask
    // main sequence
    initial begin
        {miscompares, tests_run, cyc} = 96'h0;
        {rst, tick64, sqwSrc} = 3'b100;
        repeat (12) @(negedge sys_clk);
        rst = 1'b0;
        t_rst;
        $display("reset test done");
        t_cal;
        $display("calendar test done");
        t_alarm;
        $display("alarm test done");
        t_ext;
        $display("external tick test done");
        t_ovr;
        $display("override test done");
        report_and_stop;
    end
endmodule
